// ===== src/octx_map.svh
// octx_map.svh: register offsets, field positions, reset values and sizes
// for the octal registered bus transceiver.
// assumes: included by bare name from the package and the design modules.
`ifndef OCTX_MAP_SVH
`define OCTX_MAP_SVH

`define OCTX_BUS_W          8
`define OCTX_ADDR_W         12

// register byte addresses, one aligned 32-bit word each
`define OCTX_CTRL_OFS       12'h000
`define OCTX_STORE_OFS      12'h004
`define OCTX_STATUS_OFS     12'h008

// control register fields
`define OCTX_CTRL_ALLOW_BIT 0
`define OCTX_CTRL_RESET     32'h0000_0001

// store register fields
`define OCTX_STORE_A_LSB    0
`define OCTX_STORE_B_LSB    8

// status register fields
`define OCTX_STAT_OVF_BIT   0
`define OCTX_STAT_AOE_BIT   1
`define OCTX_STAT_BOE_BIT   2

// capture log buffer: {b_hit, a_hit, b byte, a byte}
`define OCTX_LOG_W          18
`define OCTX_LOG_DEPTH      2

`endif

// ===== src/octx_pkg.sv
// octx_pkg: types shared by the transceiver modules.
// assumes: octx_map.svh is on the include path.
`include "octx_map.svh"

package octx_pkg;

    typedef logic [`OCTX_BUS_W-1:0]  octx_byte_t;
    typedef logic [`OCTX_LOG_W-1:0]  octx_log_t;
    typedef logic [`OCTX_ADDR_W-1:0] octx_addr_t;

    typedef enum logic [1:0] {
        OCTX_REG_CTRL,
        OCTX_REG_STORE,
        OCTX_REG_STATUS,
        OCTX_REG_NONE
    } octx_reg_sel_t;

endpackage : octx_pkg

// ===== src/octx_log_fifo.sv
// octx_log_fifo: two-entry buffer for capture words.
// assumes: one clock, async active-low reset; head always sits in entry 0
// so read data come straight out of a register.
`timescale 1ns/1ps
`include "octx_map.svh"

module octx_log_fifo
    import octx_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      in_valid,
    output logic           in_ready,
    input  wire octx_log_t in_data,
    output logic           out_valid,
    input  wire logic      out_ready,
    output octx_log_t      out_data
);

    octx_log_t entry0;
    octx_log_t entry1;
    logic      full0;
    logic      full1;
    octx_log_t next_entry0;
    octx_log_t next_entry1;
    logic      next_full0;
    logic      next_full1;
    logic      push;
    logic      pop;

    assign in_ready  = ~full1;
    assign out_valid = full0;
    assign out_data  = entry0;

    always_comb begin
        push        = in_valid & ~full1;
        pop         = out_ready & full0;
        next_entry0 = entry0;
        next_entry1 = entry1;
        next_full0  = full0;
        next_full1  = full1;
        if (pop) begin
            // shift the second word forward; a fresh word fills the gap
            next_entry0 = full1 ? entry1 : in_data;
            next_full0  = full1 | push;
            next_entry1 = in_data;
            next_full1  = full1 & push;
        end else if (push) begin
            if (full0) begin
                next_entry1 = in_data;
                next_full1  = 1'b1;
            end else begin
                next_entry0 = in_data;
                next_full0  = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry0 <= '0;
            entry1 <= '0;
            full0  <= 1'b0;
            full1  <= 1'b0;
        end else begin
            entry0 <= next_entry0;
            entry1 <= next_entry1;
            full0  <= next_full0;
            full1  <= next_full1;
        end
    end

endmodule : octx_log_fifo

// ===== src/octx_core.sv
// octx_core: octal registered bus transceiver with an APB status/control face.
// assumes: all pins synchronous to pclk (20 MHz); capture clocks are sampled
// inputs whose rising edges are found on pclk; the bench resolves the two
// three-state buses from the _out/_oe pairs.
//
// Notes on behaviour
// [R1] with drive enabled, select low and a-source low, port A carries live port B; select high and b-source low, port B carries live port A.
// [R2] each rising edge of a_capture_clock stores port A and each of b_capture_clock stores port B, whatever the other controls say.
// [R3] with drive disabled the outside may feed both buses and clock both registers together, and both store at once.
// [R4] with drive enabled, a-source high puts the B-side register on port A, b-source high puts the A-side register on port B, that clock held still.
// [R5] with drive disabled both ports stay undriven while capture carries on.
`timescale 1ns/1ps
`include "octx_map.svh"

module octx_core
    import octx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire octx_addr_t  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // transceiver controls
    input  wire logic        port_drive_en_n,
    input  wire logic        port_drive_select,
    input  wire logic        a_port_source_sel,
    input  wire logic        b_port_source_sel,
    input  wire logic        a_capture_clock,
    input  wire logic        b_capture_clock,
    // port A
    input  wire octx_byte_t  a_port_bits_in,
    output octx_byte_t       a_port_bits_out,
    output logic             a_port_bits_oe,
    // port B
    input  wire octx_byte_t  b_port_bits_in,
    output octx_byte_t       b_port_bits_out,
    output logic             b_port_bits_oe,
    // capture log
    output logic             cap_valid,
    input  wire logic        cap_ready,
    output octx_log_t        cap_data,
    output logic             cap_accept
);

    ////////////////////////////////////////////////////////////////////////
    // capture registers

    octx_byte_t a_store;
    octx_byte_t b_store;
    logic       a_clk_prev;
    logic       b_clk_prev;
    octx_byte_t next_a_store;
    octx_byte_t next_b_store;
    logic       a_hit;
    logic       b_hit;

    always_comb begin
        a_hit        = a_capture_clock & ~a_clk_prev;
        b_hit        = b_capture_clock & ~b_clk_prev;
        // capture ignores enable, direction and source selects
        next_a_store = a_hit ? a_port_bits_in : a_store; // R2
        next_b_store = b_hit ? b_port_bits_in : b_store; // R2
        // both edges in one cycle update both registers together
    end // R3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_store    <= '0;
            b_store    <= '0;
            a_clk_prev <= 1'b0;
            b_clk_prev <= 1'b0;
        end else begin
            a_store    <= next_a_store;
            b_store    <= next_b_store;
            a_clk_prev <= a_capture_clock;
            b_clk_prev <= b_capture_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port drivers; registered so the pads switch cleanly, one cycle late

    logic       drive_allow;
    octx_byte_t next_a_out;
    octx_byte_t next_b_out;
    logic       next_a_oe;
    logic       next_b_oe;
    logic       drive_on;

    always_comb begin
        drive_on   = ~port_drive_en_n & drive_allow;
        next_a_oe  = drive_on & ~port_drive_select; // R5
        next_b_oe  = drive_on & port_drive_select;  // R5
        next_a_out = '0;
        next_b_out = '0;
        if (next_a_oe) begin
            // stored byte is stable only while b_capture_clock is held still
            next_a_out = a_port_source_sel ? b_store : b_port_bits_in; // R1 R4
        end
        if (next_b_oe) begin
            next_b_out = b_port_source_sel ? a_store : a_port_bits_in; // R1 R4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_port_bits_out <= '0;
            b_port_bits_out <= '0;
            a_port_bits_oe  <= 1'b0;
            b_port_bits_oe  <= 1'b0;
        end else begin
            a_port_bits_out <= next_a_out;
            b_port_bits_out <= next_b_out;
            a_port_bits_oe  <= next_a_oe;
            b_port_bits_oe  <= next_b_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture log: one word per cycle with a capture edge, holding both bytes and which edges hit

    logic      log_in_ready;
    logic      log_push;
    octx_log_t log_word;
    logic      overflow;
    logic      next_overflow;
    logic      ovf_clear;

    always_comb begin
        log_push = a_hit | b_hit;
        log_word = {b_hit, a_hit, next_b_store, next_a_store};
    end

    octx_log_fifo u_log (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (log_push),
        .in_ready  (log_in_ready),
        .in_data   (log_word),
        .out_valid (cap_valid),
        .out_ready (cap_ready),
        .out_data  (cap_data)
    );

    // the pins cannot be stalled, so a capture against a full log only
    // raises the sticky flag; cap_accept repeats log_in_ready one cycle late
    always_comb begin
        next_overflow = overflow;
        if (ovf_clear) begin
            next_overflow = 1'b0;
        end
        if (log_push & ~log_in_ready) begin
            next_overflow = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow   <= 1'b0;
            cap_accept <= 1'b0;
        end else begin
            overflow   <= next_overflow;
            cap_accept <= log_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer in the second access cycle

    function automatic octx_reg_sel_t decode(input octx_addr_t addr);
        unique case (addr)
            `OCTX_CTRL_OFS:   decode = OCTX_REG_CTRL;
            `OCTX_STORE_OFS:  decode = OCTX_REG_STORE;
            `OCTX_STATUS_OFS: decode = OCTX_REG_STATUS;
            default:          decode = OCTX_REG_NONE;
        endcase
    endfunction : decode

    octx_reg_sel_t sel;
    logic          access_done;
    logic          next_pready;
    logic          next_pslverr;
    logic [31:0]   next_prdata;
    logic          next_allow;

    always_comb begin
        sel          = decode(paddr);
        access_done  = psel & penable & pready;
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & (sel == OCTX_REG_NONE);
        next_prdata  = '0;
        next_allow   = drive_allow;
        ovf_clear    = 1'b0;
        if (next_pready & ~pwrite) begin
            unique case (sel)
                OCTX_REG_CTRL: begin
                    next_prdata[`OCTX_CTRL_ALLOW_BIT] = drive_allow;
                end
                OCTX_REG_STORE: begin
                    next_prdata[`OCTX_STORE_A_LSB +: `OCTX_BUS_W] = a_store;
                    next_prdata[`OCTX_STORE_B_LSB +: `OCTX_BUS_W] = b_store;
                end
                OCTX_REG_STATUS: begin
                    next_prdata[`OCTX_STAT_OVF_BIT] = overflow;
                    next_prdata[`OCTX_STAT_AOE_BIT] = a_port_bits_oe;
                    next_prdata[`OCTX_STAT_BOE_BIT] = b_port_bits_oe;
                end
                OCTX_REG_NONE: begin
                    next_prdata = '0;
                end
            endcase
        end
        if (access_done & pwrite) begin
            if (sel == OCTX_REG_CTRL) begin
                next_allow = pwdata[`OCTX_CTRL_ALLOW_BIT];
            end
            if (sel == OCTX_REG_STATUS) begin
                ovf_clear = pwdata[`OCTX_STAT_OVF_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= '0;
            drive_allow <= 1'(`OCTX_CTRL_RESET);
        end else begin
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            prdata      <= next_prdata;
            drive_allow <= next_allow;
        end
    end

endmodule : octx_core

// ===== sim/octx_core_sva.sv
// octx_core_sva: port checks for octx_core, bound to every instance.
// assumes: capture clocks and pins move only just after pclk edges.
`timescale 1ns/1ps
`include "octx_map.svh"

module octx_core_sva
    import octx_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire octx_addr_t  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        port_drive_en_n,
    input wire logic        port_drive_select,
    input wire logic        a_port_source_sel,
    input wire logic        b_port_source_sel,
    input wire logic        a_capture_clock,
    input wire logic        b_capture_clock,
    input wire octx_byte_t  a_port_bits_in,
    input wire octx_byte_t  a_port_bits_out,
    input wire logic        a_port_bits_oe,
    input wire octx_byte_t  b_port_bits_in,
    input wire octx_byte_t  b_port_bits_out,
    input wire logic        b_port_bits_oe
);
    logic       allow, a_prev, b_prev;
    octx_byte_t a_st, b_st;
    wire        drv = !port_drive_en_n && allow;
    wire octx_byte_t a_want = a_port_source_sel ? b_st : b_port_bits_in;
    wire octx_byte_t b_want = b_port_source_sel ? a_st : a_port_bits_in;

    // mirror of drive_allow and both stores, rebuilt from the pins alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {allow, a_prev, b_prev, a_st, b_st} <= {3'h4, 16'h0000};
        end else begin
            a_prev <= a_capture_clock;
            b_prev <= b_capture_clock;
            if (a_capture_clock && !a_prev)
                a_st <= a_port_bits_in;
            if (b_capture_clock && !b_prev)
                b_st <= b_port_bits_in;
            if (psel && penable && pready && pwrite && paddr == `OCTX_CTRL_OFS)
                allow <= pwdata[`OCTX_CTRL_ALLOW_BIT];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    port_a_a: assert property (drv && !port_drive_select |=>
        a_port_bits_oe && a_port_bits_out == $past(a_want)) else $error("port a value");
    port_b_a: assert property (drv && port_drive_select |=>
        b_port_bits_oe && b_port_bits_out == $past(b_want)) else $error("port b value");
    one_bus_a: assert property (!(a_port_bits_oe && b_port_bits_oe))
        else $error("both ports driven");
    quiet_a: assert property (port_drive_en_n |=> !a_port_bits_oe && !b_port_bits_oe)
        else $error("port driven while disabled");
    store_read_a: assert property (psel && penable && pready && !pwrite
        && paddr == `OCTX_STORE_OFS |-> prdata == {16'h0000, $past(b_st), $past(a_st)})
        else $error("store readback");
endmodule : octx_core_sva

bind octx_core octx_core_sva octx_core_sva_inst (.*);

// ===== sim/octx_far_side.sv
// octx_far_side: logic beyond both buses, and the reader of the capture log.
// assumes: bench sets a_far/b_far and calls pulse and pop just after edges.
`timescale 1ns/1ps

module octx_far_side
    import octx_pkg::*;
(
    input  wire logic       pclk,
    input  wire octx_byte_t a_port_bits_out,
    input  wire logic       a_port_bits_oe,
    input  wire octx_byte_t b_port_bits_out,
    input  wire logic       b_port_bits_oe,
    output octx_byte_t      a_port_bits_in,
    output octx_byte_t      b_port_bits_in,
    output logic            a_capture_clock,
    output logic            b_capture_clock,
    output logic            cap_ready
);
    octx_byte_t a_far = 8'h00;
    octx_byte_t b_far = 8'h00;

    initial {a_capture_clock, b_capture_clock, cap_ready} = 3'h0;

    // far side backs off while the core drives, so no wire is fought over
    assign a_port_bits_in = a_port_bits_oe ? a_port_bits_out : a_far;
    assign b_port_bits_in = b_port_bits_oe ? b_port_bits_out : b_far;

    // clocks high one cycle then low, so a stored value stays still after
    task automatic pulse(input logic a, input logic b);
        @(posedge pclk);
        a_capture_clock <= a;
        b_capture_clock <= b;
        @(posedge pclk);
        {a_capture_clock, b_capture_clock} <= 2'h0;
        @(posedge pclk);
    endtask : pulse

    task automatic pop();
        @(posedge pclk);
        cap_ready <= 1'h1;
        @(posedge pclk);
        cap_ready <= 1'h0;
        @(posedge pclk);
    endtask : pop
endmodule : octx_far_side

// ===== sim/testbench.sv
// testbench: runs octx_core against octx_far_side; the apb master lives here.
// assumes: no capture edge lands next to a store read.
`timescale 1ns/1ps
`include "octx_map.svh"

module testbench
    import octx_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cap_valid;
    logic        port_drive_en_n, port_drive_select, a_port_source_sel, b_port_source_sel;
    logic        a_capture_clock, b_capture_clock, a_port_bits_oe, b_port_bits_oe;
    logic        cap_ready, cap_accept;
    octx_addr_t  paddr;
    logic [31:0] pwdata, prdata, rd;
    octx_byte_t  a_port_bits_in, a_port_bits_out, b_port_bits_in, b_port_bits_out;
    octx_log_t   cap_data;
    int          error_cnt = 0, checks = 0, cyc = 0;

    octx_core     octx_core_inst (.*);
    octx_far_side octx_far_side_inst (.*);

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input octx_addr_t addr, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, wr, addr, wd};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (!pready && ++n < 20);
        rd = prdata;
        // a wait that ran out of patience leaves pready low here
        check("pready", pready, 1'h1);
        check("pslverr", pslverr, addr > `OCTX_STATUS_OFS);
        {psel, penable} <= 2'h0;
    endtask : apb

    // c is {drive_en_n, drive_select, a_source, b_source}
    task automatic pins(input logic [3:0] c, input octx_byte_t a, b);
        @(posedge pclk);
        {port_drive_en_n, port_drive_select, a_port_source_sel, b_port_source_sel} <= c;
        octx_far_side_inst.a_far <= a;
        octx_far_side_inst.b_far <= b;
        // one extra edge: the port that was driven still shows the old byte
        // for a cycle after a direction change
        repeat (3) @(posedge pclk);
    endtask : pins

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'h0, `OCTX_CTRL_OFS, 32'h0);
        check("ctrl", rd, `OCTX_CTRL_RESET);
        apb(1'h0, 12'h00c, 32'h0);
        check("unmapped", rd, 32'h0);
        apb(1'h1, `OCTX_CTRL_OFS, 32'h0);
        pins(4'h4, 8'h12, 8'h34);
        check("gated", b_port_bits_oe, 1'h0);
        apb(1'h1, `OCTX_CTRL_OFS, 32'h1);
        $display("regs done");
    endtask : t_regs

    task automatic t_live();
        pins(4'h0, 8'ha5, 8'h5a);
        check("a live", {a_port_bits_oe, b_port_bits_oe, a_port_bits_out}, 10'h25a);
        pins(4'h4, 8'ha5, 8'h5a);
        check("b live", {a_port_bits_oe, b_port_bits_oe, b_port_bits_out}, 10'h1a5);
        pins(4'h8, 8'ha5, 8'h5a);
        check("quiet", {a_port_bits_oe, b_port_bits_oe}, 2'h0);
        $display("live done");
    endtask : t_live

    task automatic t_store();
        octx_far_side_inst.pulse(1'h1, 1'h1);
        apb(1'h0, `OCTX_STORE_OFS, 32'h0);
        check("both stored", rd, 32'h5aa5);
        pins(4'h2, 8'h77, 8'h88);
        check("a stored", a_port_bits_out, 8'h5a);
        pins(4'h5, 8'h77, 8'h88);
        check("b stored", b_port_bits_out, 8'ha5);
        pins(4'h4, 8'h11, 8'h88);
        octx_far_side_inst.pulse(1'h1, 1'h0);
        apb(1'h1, `OCTX_STORE_OFS, 32'hffff);
        apb(1'h0, `OCTX_STORE_OFS, 32'h0);
        check("a while driving", rd, 32'h5a11);
        $display("store done");
    endtask : t_store

    task automatic t_log();
        check("full", {cap_valid, cap_accept, cap_data}, {2'h2, 2'h3, 16'h5aa5});
        octx_far_side_inst.pulse(1'h1, 1'h0);
        apb(1'h0, `OCTX_STATUS_OFS, 32'h0);
        // overflow set, port B driven, port A quiet
        check("status", rd[`OCTX_STAT_BOE_BIT:`OCTX_STAT_OVF_BIT], 3'h5);
        octx_far_side_inst.pop();
        check("second", {cap_valid, cap_data}, {1'h1, 2'h1, 16'h5a11});
        octx_far_side_inst.pop();
        check("empty", cap_valid, 1'h0);
        apb(1'h1, `OCTX_STATUS_OFS, 32'h1);
        apb(1'h0, `OCTX_STATUS_OFS, 32'h0);
        check("cleared", rd[`OCTX_STAT_OVF_BIT], 1'h0);
        $display("log done");
    endtask : t_log

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {port_drive_en_n, port_drive_select, a_port_source_sel, b_port_source_sel} = 4'h8;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_live();
        t_store();
        t_log();
        close_out();
    end
endmodule : testbench
